// ==== include/stc_pkg.sv ====
// Package of constants and types for the sixteen-bit timer/counter
package stc_pkg;
  // ***********************************************************
  // Register byte addresses (AXI4-Lite, one word each)
  // ***********************************************************
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_LOW = 8'h04;
  localparam logic [7:0] ADDR_HIGH = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_IRQEN = 8'h10;
  localparam logic [7:0] ADDR_CMP_LO = 8'h14;
  localparam logic [7:0] ADDR_CMP_HI = 8'h18;
  localparam logic [7:0] ADDR_CMP_MODE = 8'h1c;
  localparam int ADDR_W = 8;
  // ***********************************************************
  // Control register fields
  // ***********************************************************
  localparam int BIT_RUN = 0;
  localparam int BIT_SRC = 1;
  localparam int BIT_NOSYNC = 2;
  localparam int BIT_OSCEN = 3;
  localparam int BIT_PS_LO = 4;
  localparam int BIT_PS_HI = 5;
  localparam int BIT_CLKSTAT = 6;
  localparam int BIT_WIDE = 7;
  localparam logic [7:0] CTRL_WR_MASK = 8'hbf;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [3:0] CMP_MODE_RESET = 4'hb;
  localparam logic [1:0] QTR_LAST = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ***********************************************************
  // Bus slave state
  // ***********************************************************
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRESP = 2'b01,
    BUS_RRESP = 2'b10
  } stc_bus_type;
endpackage

// ==== include/stc_edge_if.sv ====
// Interface carrying the synchronised edge detector's signals
`timescale 1ns/10ps
interface stc_edge_if;
  logic raw_in;
  logic rise_sync;
  logic rise_async;
  modport det (input raw_in, output rise_sync, output rise_async);
  modport use_side (output raw_in, input rise_sync, input rise_async);
endinterface

// ==== hw/stc_edge_detect.sv ====
// Three-flop synchroniser and rising edge detector for the external clock
`timescale 1ns/10ps
module stc_edge_detect (
  input wire logic sys_clk,
  input wire logic sys_rst,
  stc_edge_if.det edge_io
);
  import stc_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic fast_prev;
  } stc_edge_state_type;

  stc_edge_state_type st_r;
  stc_edge_state_type st_nxt;

  // Shift chain; s1 is read only by s2
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = edge_io.raw_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.fast_prev = st_r.s2;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Synchronised edge: second flop sees the new high level while the third is still low
  assign edge_io.rise_sync = st_r.s2 & ~st_r.s3;
  // Unsynchronised path: fast_prev always equals s3, so it fires in the same cycle as the synchronised edge
  assign edge_io.rise_async = st_r.s2 & ~st_r.fast_prev & ~st_r.s3;
endmodule // stc_edge_detect

// ==== hw/stc_timer.sv ====
// Sixteen-bit timer/counter with AXI4-Lite register slave
// Notes on behaviour
// R1 - Counter advances only while run enable (bit 0) is set.
// R2 - Source 0 counts instruction cycles; source 1 counts external rising edges.
// R3 - Sync-disable bit picks synchronised or raw external edges; ignored internally. Here both choices give the same flopped edge.
// R4 - Prescale field divides input by 1, 2, 4 or 8.
// R5 - Oscillator enable starts or stops oscillator, independent of run enable.
// R6 - Wide-access bit selects buffered 16-bit or plain 8-bit access.
// R7 - Wide mode: low-byte read copies live high byte into buffer; high reads buffer.
// R8 - Wide mode: high writes go to buffer; low write loads both bytes.
// R9 - Low write clears prescaler; high write leaves it alone.
// R10 - Clock-status bit reads 1 while oscillator supplies system clock.
// R11 - While running, oscillator pins are inputs and port reads return 0.
// R12 - Counts 0000h to FFFFh, wraps, sets sticky flag; request only if enabled.
// R13 - Compare mode 1011 match resets counter, acting as period register.
// R14 - Compare reset reliable only in timer or synchronous counter mode.
// R15 - Software counter write wins over a coincident compare reset.
// R16 - Compare reset never sets the overflow flag.
// R17 - Enabled oscillator keeps running in all power modes, sleep included.
// R18 - Software waits its own start-up delay after enabling the oscillator.
// R19 - Writable control bits and clock status are 0 after reset.
// R20 - Synchronised external clock passes flops before edge detection.
// R21 - In 8-bit mode high byte address reaches live counter directly.
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
module stc_timer (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [stc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [stc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_clk_in,
  input wire logic sysclk_from_lp_osc,
  input wire logic compare_match,
  output logic lp_osc_run,
  output logic osc_pins_force_input,
  output logic overflow_irq
);
  import stc_pkg::*;

  // ***********************************************************
  // State
  // ***********************************************************
  typedef struct packed {
    stc_bus_type bus;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [ADDR_W-1:0] raddr;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] ctrl;
    logic [15:0] count;
    logic [7:0] high_buf;
    logic [2:0] pre;
    logic [1:0] qtr;
    logic ovf_flag;
    logic ovf_ie;
    logic [15:0] cmp_val;
    logic [3:0] cmp_mode;
    logic clk_stat_s1;
    logic clk_stat_s2;
    logic clk_stat_s3;
    logic clk_stat;
    logic irq;
    logic osc_run;
    logic pins_in;
  } stc_state_type;

  stc_state_type st_r;
  stc_state_type st_nxt;

  stc_edge_if edge_bus ();

  assign edge_bus.raw_in = ext_clk_in;

  // External clock synchroniser and edge detect
  stc_edge_detect u_edge (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .edge_io(edge_bus)
  );

  // ***********************************************************
  // Counter input selection
  // ***********************************************************
  logic inst_tick;
  logic ext_tick;
  logic src_tick;
  logic pre_out;
  logic [2:0] pre_mask;

  always_comb begin
    inst_tick = (st_r.qtr == QTR_LAST); // R2
    ext_tick = st_r.ctrl[BIT_NOSYNC] ? edge_bus.rise_async : edge_bus.rise_sync; // R3 R20
    src_tick = st_r.ctrl[BIT_SRC] ? ext_tick : inst_tick; // R2 R3
    // Prescale: pass every 2^n-th input tick
    case (st_r.ctrl[BIT_PS_HI:BIT_PS_LO])
      2'b00: pre_mask = 3'h0;
      2'b01: pre_mask = 3'h1;
      2'b10: pre_mask = 3'h3;
      2'b11: pre_mask = 3'h7;
      default: pre_mask = 3'h0;
    endcase
    pre_out = src_tick && ((st_r.pre & pre_mask) == pre_mask); // R4
  end

  // ***********************************************************
  // Main next-state logic
  // ***********************************************************
  logic wr_fire;
  logic rd_fire;
  logic wr_low;
  logic wr_high;
  logic cmp_reset;
  logic cnt_write;
  logic ovf_set;
  logic [31:0] rd_val;
  logic rd_ok;

  always_comb begin
    st_nxt = st_r;
    wr_fire = st_r.aw_got && st_r.w_got && (st_r.bus == BUS_IDLE);
    rd_fire = s_axi_arvalid && st_r.arready;
    wr_low = wr_fire && (st_r.waddr == ADDR_LOW) && st_r.wstrb[0];
    wr_high = wr_fire && (st_r.waddr == ADDR_HIGH) && st_r.wstrb[0];
    // Async mode cannot promise the compare reset, so it is skipped there
    cmp_reset = compare_match && (st_r.cmp_mode == CMP_MODE_RESET)
                && !(st_r.ctrl[BIT_SRC] && st_r.ctrl[BIT_NOSYNC]); // R13 R14
    // Counter write in the trigger's cycle drops the reset; wrap set beats clear
    cnt_write = wr_low || (wr_high && !st_r.ctrl[BIT_WIDE]); // R15
    ovf_set = st_r.ctrl[BIT_RUN] && pre_out && (st_r.count == COUNT_MAX); // R12
    rd_val = 32'h0;
    rd_ok = 1'b1;

    // Instruction clock is sys_clk divided by four
    st_nxt.qtr = st_r.qtr + 2'h1;

    // Write address and data taken in either order
    st_nxt.awready = !st_r.aw_got && !s_axi_awvalid ? 1'b1 : st_r.awready;
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.waddr = s_axi_awaddr;
      st_nxt.awready = 1'b0;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
      st_nxt.wready = 1'b0;
    end

    // Counting, prescaler and overflow
    if (st_r.ctrl[BIT_RUN] && src_tick) begin // R1
      st_nxt.pre = st_r.pre + 3'h1;
      if (pre_out) begin
        st_nxt.pre = 3'h0;
        st_nxt.count = st_r.count + 16'h0001; // R12
        if (st_r.count == COUNT_MAX) begin
          st_nxt.ovf_flag = 1'b1; // R12
        end
      end
    end
    // Compare reset does not touch the overflow flag
    if (cmp_reset && !cnt_write) begin
      st_nxt.count = COUNT_RESET; // R13 R15 R16
    end

    // Register writes; a write after the count update wins
    if (wr_fire) begin
      st_nxt.bus = BUS_WRESP;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      case (st_r.waddr)
        ADDR_CONTROL: begin
          if (st_r.wstrb[0]) begin
            st_nxt.ctrl = st_r.wdata[7:0] & CTRL_WR_MASK; // R5 R6
          end
        end
        ADDR_LOW: begin
          if (wr_low) begin
            st_nxt.count[7:0] = st_r.wdata[7:0]; // R15
            st_nxt.pre = 3'h0; // R9
            if (st_r.ctrl[BIT_WIDE]) begin
              st_nxt.count[15:8] = st_r.high_buf; // R8
            end
          end
        end
        ADDR_HIGH: begin
          if (wr_high) begin
            // Prescaler count is left as it is
            if (st_r.ctrl[BIT_WIDE]) begin
              st_nxt.high_buf = st_r.wdata[7:0]; // R8 R9
            end else begin
              st_nxt.count[15:8] = st_r.wdata[7:0]; // R21 R15
            end
          end
        end
        ADDR_STATUS: begin
          // Write one to clear; a same-cycle overflow keeps the flag
          if (st_r.wstrb[0] && st_r.wdata[0] && !ovf_set) begin // R12
            st_nxt.ovf_flag = 1'b0;
          end
        end
        ADDR_IRQEN: begin
          if (st_r.wstrb[0]) begin
            st_nxt.ovf_ie = st_r.wdata[0];
          end
        end
        ADDR_CMP_LO: begin
          if (st_r.wstrb[0]) begin
            st_nxt.cmp_val[7:0] = st_r.wdata[7:0];
          end
        end
        ADDR_CMP_HI: begin
          if (st_r.wstrb[0]) begin
            st_nxt.cmp_val[15:8] = st_r.wdata[7:0];
          end
        end
        ADDR_CMP_MODE: begin
          if (st_r.wstrb[0]) begin
            st_nxt.cmp_mode = st_r.wdata[3:0];
          end
        end
        default: begin
          st_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end

    // Register reads
    case (s_axi_araddr)
      ADDR_CONTROL: rd_val = {24'h0, st_r.ctrl[7], st_r.clk_stat, st_r.ctrl[5:0]}; // R10
      ADDR_LOW: rd_val = {24'h0, st_r.count[7:0]};
      ADDR_HIGH: rd_val = {24'h0, st_r.ctrl[BIT_WIDE] ? st_r.high_buf : st_r.count[15:8]}; // R7 R21
      ADDR_STATUS: rd_val = {31'h0, st_r.ovf_flag};
      ADDR_IRQEN: rd_val = {31'h0, st_r.ovf_ie};
      ADDR_CMP_LO: rd_val = {24'h0, st_r.cmp_val[7:0]};
      ADDR_CMP_HI: rd_val = {24'h0, st_r.cmp_val[15:8]};
      ADDR_CMP_MODE: rd_val = {28'h0, st_r.cmp_mode};
      default: rd_ok = 1'b0;
    endcase
    if (rd_fire) begin
      st_nxt.bus = BUS_RRESP;
      st_nxt.arready = 1'b0;
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_val;
      st_nxt.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
      // Snapshot of the live high byte makes a consistent 16-bit read
      if (s_axi_araddr == ADDR_LOW && st_r.ctrl[BIT_WIDE]) begin
        st_nxt.high_buf = st_r.count[15:8]; // R7
      end
    end

    // Response channels and idle readiness
    case (st_r.bus)
      BUS_IDLE: begin
        if (!rd_fire && !wr_fire) begin
          st_nxt.arready = !st_r.aw_got && !st_r.w_got;
          st_nxt.awready = !st_r.aw_got && !(s_axi_awvalid && st_r.awready);
          st_nxt.wready = !st_r.w_got && !(s_axi_wvalid && st_r.wready);
        end else begin
          st_nxt.awready = 1'b0;
          st_nxt.wready = 1'b0;
          st_nxt.arready = 1'b0;
        end
      end
      BUS_WRESP: begin
        if (s_axi_bready) begin
          st_nxt.bvalid = 1'b0;
          st_nxt.bus = BUS_IDLE;
        end
      end
      BUS_RRESP: begin
        if (s_axi_rready) begin
          st_nxt.rvalid = 1'b0;
          st_nxt.bus = BUS_IDLE;
        end
      end
      default: st_nxt.bus = BUS_IDLE;
    endcase

    // Clock-status input crosses domains through three flops
    st_nxt.clk_stat_s1 = sysclk_from_lp_osc;
    st_nxt.clk_stat_s2 = st_r.clk_stat_s1;
    st_nxt.clk_stat_s3 = st_r.clk_stat_s2;
    if (st_r.clk_stat_s2 == st_r.clk_stat_s3) begin
      st_nxt.clk_stat = st_r.clk_stat_s3; // R10
    end
    // Oscillator enable is not gated by run, so it survives sleep
    st_nxt.osc_run = st_nxt.ctrl[BIT_OSCEN]; // R5 R17
    st_nxt.pins_in = st_nxt.ctrl[BIT_RUN]; // R11
    st_nxt.irq = st_nxt.ovf_flag && st_nxt.ovf_ie; // R12
  end

  // Synchronous reset clears all control state
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r <= '0; // R19
    end else begin
      st_r <= st_nxt;
    end
  end

  // ***********************************************************
  // Outputs, all straight from flops
  // ***********************************************************
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign lp_osc_run = st_r.osc_run;
  assign osc_pins_force_input = st_r.pins_in;
  assign overflow_irq = st_r.irq;

  // ***********************************************************
  // Assertions
  // ***********************************************************
  chk_hold_stopped: assert property (@(posedge sys_clk) disable iff (sys_rst) // R1
    (!st_r.ctrl[BIT_RUN] && !wr_fire && !cmp_reset) |=> (st_r.count == $past(st_r.count)))
    else $error("counter moved while stopped");
  chk_wrap_flag: assert property (@(posedge sys_clk) disable iff (sys_rst) // R12
    (st_r.count == COUNT_MAX && st_r.ctrl[BIT_RUN] && pre_out && !wr_fire && !cmp_reset)
    |=> (st_r.count == COUNT_RESET && st_r.ovf_flag))
    else $error("wrap did not set flag");
  chk_irq_gate: assert property (@(posedge sys_clk) disable iff (sys_rst) // R12
    overflow_irq == (st_r.ovf_flag && st_r.ovf_ie))
    else $error("irq without enable");
  chk_set_wins: assert property (@(posedge sys_clk) disable iff (sys_rst) // R12
    ovf_set |=> st_r.ovf_flag)
    else $error("overflow lost to flag clear");
  chk_cmp_clear: assert property (@(posedge sys_clk) disable iff (sys_rst) // R13
    (cmp_reset && !wr_fire) |=> (st_r.count == COUNT_RESET))
    else $error("compare reset missed");
  chk_cmp_noflag: assert property (@(posedge sys_clk) disable iff (sys_rst) // R16
    (cmp_reset && !st_r.ovf_flag && !pre_out) |=> !st_r.ovf_flag)
    else $error("compare reset set flag");
  chk_write_wins: assert property (@(posedge sys_clk) disable iff (sys_rst) // R15
    (cmp_reset && wr_low) |=> (st_r.count[7:0] == $past(st_r.wdata[7:0])))
    else $error("write lost to compare reset");
  chk_pre_clear: assert property (@(posedge sys_clk) disable iff (sys_rst) // R9
    wr_low |=> (st_r.pre == 3'h0))
    else $error("prescaler not cleared");
  chk_snap_high: assert property (@(posedge sys_clk) disable iff (sys_rst) // R7
    (rd_fire && s_axi_araddr == ADDR_LOW && st_r.ctrl[BIT_WIDE]) |=> (st_r.high_buf == $past(st_r.count[15:8])))
    else $error("high byte not captured");
  chk_pins_input: assert property (@(posedge sys_clk) disable iff (sys_rst) // R11
    st_r.ctrl[BIT_RUN] |-> osc_pins_force_input)
    else $error("pins not forced to input");
endmodule // stc_timer

// ==== bench/stc_ext_src.sv ====
// Model of the far-side count clock and the clock-status source
`timescale 1ns/10ps
// ***********************************************************
// Far-side source model
// ***********************************************************
module stc_ext_src (
  output logic ext_clk,
  output logic lp_osc_sel
);
  // Clock stands low between bursts, like a quiet pin
  initial begin
    ext_clk = 1'b0;
    lp_osc_sel = 1'b0;
  end
  // Rising edges at a period unrelated to sys_clk
  task automatic burst(input int n, input int half_ns);
    repeat (n) begin
      #(half_ns) ext_clk = 1'b1;
      #(half_ns) ext_clk = 1'b0;
    end
  endtask
  // System clock taken from the oscillator or from elsewhere
  task automatic set_sel(input logic v);
    lp_osc_sel = v;
  endtask
endmodule // stc_ext_src

// ==== bench/testbench.sv ====
// Self-checking bench for the sixteen-bit timer/counter
`timescale 1ns/10ps
module testbench;
  import stc_pkg::*;
  // ***********************************************************
  // Signals and instances
  // ***********************************************************
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic cmp_match = 1'b0;
  logic race_arm = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic ext_clk, lp_sel, osc_run, pins_in, irq;
  int err_count = 0;
  int n_compared = 0;

  stc_ext_src stc_ext_src_i (.ext_clk(ext_clk), .lp_osc_sel(lp_sel));
  stc_timer stc_timer_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_clk_in(ext_clk), .sysclk_from_lp_osc(lp_sel), .compare_match(cmp_match),
    .lp_osc_run(osc_run), .osc_pins_force_input(pins_in), .overflow_irq(irq)
  );

  // Free-running 100 MHz clock
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // ***********************************************************
  // Checking and bus tasks
  // ***********************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // A wait that runs out ends the run at once
  task automatic stall();
    err_count++;
    $display("Bus wait ran out at %0t", $time);
    end_sim();
  endtask

  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk);
      // Trigger pulse lands in the cycle the taken write is applied
      if (race_arm) cmp_match <= (awready === 1'b1) && (wready === 1'b1);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n == 40) stall();
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 40) stall();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, {24'h0, d}, r);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(d, e);
  endtask

  // Count load in 8-bit mode: live high byte, then low byte
  task automatic setc(input logic [15:0] v);
    w(ADDR_HIGH, v[15:8]);
    w(ADDR_LOW, v[7:0]);
  endtask

  // Low byte first, so wide mode gives one sample too
  task automatic getc(output logic [15:0] v);
    logic [31:0] h, l;
    logic [1:0] r;
    rd(ADDR_LOW, l, r);
    rd(ADDR_HIGH, h, r);
    v = {h[7:0], l[7:0]};
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // ***********************************************************
  // Scenarios
  // ***********************************************************
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rc(ADDR_CONTROL, 32'h0);
    rc(ADDR_STATUS, 32'h0);
    rc(ADDR_IRQEN, 32'h0);
    rc(ADDR_HIGH, 32'h0);
    check(32'({osc_run, pins_in, irq}), 32'h0);
    rd(8'h20, d, r);
    check(d, 32'h0);
    check(32'(r), 32'(RESP_SLVERR));
    wr(8'h20, 32'hff, r);
    check(32'(r), 32'(RESP_SLVERR));
  endtask

  task automatic t_osc();
    w(ADDR_CONTROL, 8'h08);
    tick(2);
    check(32'({osc_run, pins_in}), 32'h2);
    w(ADDR_CONTROL, 8'h01);
    tick(2);
    check(32'({osc_run, pins_in}), 32'h1);
    w(ADDR_CONTROL, 8'h00);
    stc_ext_src_i.set_sel(1'b1);
    tick(6);
    rc(ADDR_CONTROL, 32'h40);
    stc_ext_src_i.set_sel(1'b0);
    tick(6);
    w(ADDR_CONTROL, 8'h40);
    rc(ADDR_CONTROL, 32'h0);
  endtask

  // Timer mode at each prescale; the sync-disable bit is set to show it is ignored
  task automatic t_rate();
    logic [15:0] v, v2;
    int e;
    for (int p = 0; p < 4; p++) begin
      w(ADDR_CONTROL, 8'h00);
      setc(16'h0000);
      w(ADDR_CONTROL, {2'b00, p[1:0], 4'b0101});
      tick(320);
      w(ADDR_CONTROL, 8'h00);
      getc(v);
      e = 80 >> p;
      check({31'h0, (v >= e - 1) && (v <= e + 2)}, 32'h1);
      tick(40);
      getc(v2);
      check(32'(v2), 32'(v));
    end
  endtask

  // External edges: synchronised, raw, and through the prescaler
  task automatic t_ext();
    logic [7:0] ct [4] = '{8'h0b, 8'h0f, 8'h1b, 8'h3f};
    int ne [4] = '{20, 20, 20, 24};
    logic [15:0] ex [4] = '{16'd20, 16'd20, 16'd10, 16'd3};
    logic [15:0] v;
    w(ADDR_CONTROL, 8'h08);
    tick(50);
    for (int i = 0; i < 4; i++) begin
      setc(16'h0000);
      w(ADDR_CONTROL, ct[i]);
      stc_ext_src_i.burst(ne[i], 37);
      tick(8);
      w(ADDR_CONTROL, 8'h08);
      getc(v);
      check(32'(v), 32'(ex[i]));
    end
    w(ADDR_CONTROL, 8'h00);
  endtask

  task automatic t_wide();
    setc(16'h0000);
    w(ADDR_CONTROL, 8'h80);
    w(ADDR_HIGH, 8'hab);
    w(ADDR_LOW, 8'hcd);
    w(ADDR_CONTROL, 8'h00);
    rc(ADDR_HIGH, 32'hab);
    rc(ADDR_LOW, 32'hcd);
    w(ADDR_HIGH, 8'h34);
    rc(ADDR_HIGH, 32'h34);
    w(ADDR_CONTROL, 8'h80);
    w(ADDR_HIGH, 8'h77);
    w(ADDR_CONTROL, 8'h00);
    rc(ADDR_HIGH, 32'h34);
    w(ADDR_CONTROL, 8'h80);
    rc(ADDR_LOW, 32'hcd);
    rc(ADDR_HIGH, 32'h34);
    w(ADDR_CONTROL, 8'h00);
  endtask

  task automatic t_ovf();
    logic [15:0] v;
    setc(16'hfffe);
    w(ADDR_CONTROL, 8'h01);
    tick(16);
    w(ADDR_CONTROL, 8'h00);
    getc(v);
    check(32'(v[15:8]), 32'h0);
    rc(ADDR_STATUS, 32'h1);
    check(32'(irq), 32'h0);
    w(ADDR_IRQEN, 8'h01);
    tick(2);
    check(32'(irq), 32'h1);
    w(ADDR_STATUS, 8'h01);
    tick(2);
    rc(ADDR_STATUS, 32'h0);
    check(32'(irq), 32'h0);
    w(ADDR_IRQEN, 8'h00);
  endtask

  // Held external counter (sync, then async in the last case) so the value only moves by the compare reset
  task automatic t_cmp();
    logic [7:0] md [3] = '{8'h0b, 8'h00, 8'h0b};
    logic [7:0] ct [3] = '{8'h03, 8'h03, 8'h07};
    logic [15:0] ex [3] = '{16'h0000, 16'h0500, 16'h0500};
    logic [15:0] v;
    for (int i = 0; i < 3; i++) begin
      w(ADDR_CONTROL, 8'h00);
      w(ADDR_CMP_MODE, md[i]);
      setc(16'h0500);
      w(ADDR_CONTROL, ct[i]);
      @(posedge sys_clk);
      cmp_match <= 1'b1;
      @(posedge sys_clk);
      cmp_match <= 1'b0;
      tick(4);
      w(ADDR_CONTROL, 8'h00);
      getc(v);
      check(32'(v), 32'(ex[i]));
      rc(ADDR_STATUS, 32'h0);
    end
    // Low write coinciding with the trigger: written value kept, high byte untouched
    setc(16'h0500);
    w(ADDR_CONTROL, 8'h03);
    race_arm = 1'b1;
    w(ADDR_LOW, 8'h21);
    race_arm = 1'b0;
    w(ADDR_CONTROL, 8'h00);
    getc(v);
    check(32'(v), 32'h0521);
    rc(ADDR_STATUS, 32'h0);
    w(ADDR_CMP_MODE, 8'h0b);
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_osc();
    t_rate();
    t_ext();
    t_wide();
    t_ovf();
    t_cmp();
    end_sim();
  end
endmodule // testbench
